// ---- pkg/ols_params.svh ----
`ifndef OLS_PARAMS_SVH
`define OLS_PARAMS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OLS_REG_CTRL 6'h00
`define OLS_REG_REPEAT 6'h04
`define OLS_REG_VOLT_APPEND 6'h08
`define OLS_REG_CURR_APPEND 6'h0c
`define OLS_REG_DWELL_APPEND 6'h10
`define OLS_REG_CLEAR 6'h14
`define OLS_REG_LENGTHS 6'h18
`define OLS_REG_STATUS 6'h1c
`define OLS_REG_IRQ_STATUS 6'h20
`define OLS_REG_IRQ_MASK 6'h24
`define OLS_REG_DIRECT_VOLT 6'h28
`define OLS_REG_DIRECT_CURR 6'h2c
`define OLS_REG_TRIGGER 6'h30
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OLS_CTRL_STEP_ONCE 0
`define OLS_CTRL_CURR_LIST 1
`define OLS_CTRL_VOLT_LIST 2
`define OLS_CTRL_ARMED 3
`define OLS_IRQ_MISMATCH 0
`define OLS_IRQ_DONE 1
`define OLS_IRQ_REJECT 2
`define OLS_VOLTAGE_POINT_LIST 0
`define OLS_CURRENT_POINT_LIST 1
`define OLS_LIST_DWELL 2
// ----------------------------------------------------------------------------
// Reset values, limits and timing
// ----------------------------------------------------------------------------
`define OLS_CTRL_RESET 4'h0
`define OLS_REPEAT_RESET 32'h0000_0001
`define OLS_ENDLESS_LIMIT 32'd65534
`define OLS_MAX_POINTS 20
`define OLS_DWELL_MIN 16'd1
`define OLS_DWELL_MAX 16'd6500
`define OLS_CLOCK_PERIOD_NS 50
`define OLS_DWELL_UNIT_NS 10000000
`define OLS_DWELL_TICK_CYCLES (`OLS_DWELL_UNIT_NS / `OLS_CLOCK_PERIOD_NS)
`endif

// ---- pkg/ols_pkg.sv ----
package ols_pkg;
	// Width of one stored set-point or dwell entry.
	typedef logic [15:0] ols_point_t;
	// Sequencer states.
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_APPLY, S_DWELL, S_HOLD} ols_state_t;
endpackage

// ---- verilog/ols_point_mem.sv ----
module ols_point_mem #(
	parameter int DEPTH = 20,
	parameter int AW = 5
) (
	input wire logic clock, // System clock.
	input wire logic we, // Write strobe.
	input wire logic [AW-1:0] waddr, // Write address.
	input wire ols_pkg::ols_point_t wdata, // Write data.
	input wire logic [AW-1:0] raddr, // Read address.
	output ols_pkg::ols_point_t rdata // Registered read data.
);
	import ols_pkg::*;

	ols_point_t mem [DEPTH];

	// Storage has no reset; lengths kept elsewhere say which entries are valid.
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // ols_point_mem

// ---- verilog/ols_list_sequencer.sv ----
// Summary of operation
// - Each of the voltage, current and dwell lists holds from one to twenty points.
// - Unequal list lengths raise an error when the first point is triggered.
// - A one-point list acts as long as the others, repeating its single value.
// - Every sequencer command and every list source selection aborts a pending or running sequence.
// - The repeat count takes 1 and up, above 65534 means endless, and resets to 1.
// - The whole list runs the programmed number of times before it counts as finished.
// - Current points are applied in loading order and at most twenty are kept.
// - Voltage points are kept as an ordered list of up to twenty, applied in loading order.
// - Each dwell entry holds its point for that time, 0.01 s to 65 s.
// - In automatic mode, the reset default, one trigger runs all points back to back.
// - In single-step mode a trigger advances one point, which is then held until the next trigger.
// - Triggers during a running dwell are ignored.
// - Length queries return only entry counts, never stored values.
// - Fixed current source keeps the list off the current; list source lets it in, direct levels still apply.
// - Triggers act only while armed.
`include "ols_params.svh"
module ols_list_sequencer #(
	parameter int MAX_POINTS = `OLS_MAX_POINTS,
	parameter int TICK_CYCLES = `OLS_DWELL_TICK_CYCLES
) (
	input wire logic clock, // 20 MHz system clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [5:0] address, // Avalon byte address.
	input wire logic read, // Avalon read request.
	input wire logic write, // Avalon write request.
	input wire logic [31:0] writedata, // Avalon write data.
	output logic [31:0] readdata, // Avalon read data.
	output logic waitrequest, // Avalon wait request.
	input wire logic trigger, // Trigger event pulse.
	output ols_pkg::ols_point_t volt_out, // Voltage set-point to the output stage.
	output ols_pkg::ols_point_t curr_out, // Current set-point to the output stage.
	output logic irq // Level interrupt.
);
	import ols_pkg::*;

	localparam int AW = $clog2(MAX_POINTS + 1);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	if (MAX_POINTS < 2 || MAX_POINTS > 31 || TICK_CYCLES < 1) begin : g_check
		$error("ols_list_sequencer: unsupported parameter values");
	end

	// ------------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------------
	logic access, wr_en, rd_en, seq_cmd, trig_wr, direct_v, direct_c;
	logic [3:0] ctrl;
	logic [31:0] repeat_count_setting;
	logic [2:0] irq_status, irq_mask, events;
	logic [AW-1:0] len [3];
	logic [AW-1:0] raddr [3];
	ols_point_t rdata [3];
	logic [2:0] append;
	logic reject;
	ols_state_t state;
	logic [AW-1:0] idx, n_pts;
	logic [15:0] pass;
	logic [TW-1:0] tick_cnt;
	logic [15:0] dwell_left;

	// One wait cycle per access keeps read data a clean register.
	always_ff @(posedge clock) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	assign access = (read || write) && !waitrequest;
	assign wr_en = access && write;
	assign rd_en = (read || write) && waitrequest && read;
	assign trig_wr = wr_en && address == `OLS_REG_TRIGGER;
	assign direct_v = wr_en && address == `OLS_REG_DIRECT_VOLT;
	assign direct_c = wr_en && address == `OLS_REG_DIRECT_CURR;
	assign append[`OLS_VOLTAGE_POINT_LIST] = wr_en && address == `OLS_REG_VOLT_APPEND;
	assign append[`OLS_CURRENT_POINT_LIST] = wr_en && address == `OLS_REG_CURR_APPEND;
	assign append[`OLS_LIST_DWELL] = wr_en && address == `OLS_REG_DWELL_APPEND;
	// Every write that edits list setup also aborts the sequence.
	assign seq_cmd = wr_en && (address == `OLS_REG_CTRL || address == `OLS_REG_REPEAT ||
		address == `OLS_REG_CLEAR || append != 3'b000);

	// Control and repeat registers.
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl <= `OLS_CTRL_RESET;
			repeat_count_setting <= `OLS_REPEAT_RESET;
		end else if (wr_en && address == `OLS_REG_CTRL) begin
			ctrl <= writedata[3:0];
		end else if (wr_en && address == `OLS_REG_REPEAT) begin
			// Zero lies below the legal range and is taken as one.
			repeat_count_setting <= (writedata == 32'h0) ? `OLS_REPEAT_RESET : writedata;
		end
	end

	// Read mux; lengths are counts only, stored points are never readable.
	always_ff @(posedge clock) begin
		if (rst) begin
			readdata <= 32'h0;
		end else if (rd_en) begin
			if (address == `OLS_REG_CTRL) begin
				readdata <= {28'h0, ctrl};
			end else if (address == `OLS_REG_REPEAT) begin
				readdata <= repeat_count_setting;
			end else if (address == `OLS_REG_LENGTHS) begin
				readdata <= {8'h0, 3'h0, len[`OLS_LIST_DWELL], 3'h0, len[`OLS_CURRENT_POINT_LIST],
					3'h0, len[`OLS_VOLTAGE_POINT_LIST]};
			end else if (address == `OLS_REG_STATUS) begin
				readdata <= {pass, 3'h0, idx, 6'h0, state == S_HOLD, state != S_IDLE};
			end else if (address == `OLS_REG_IRQ_STATUS) begin
				readdata <= {29'h0, irq_status};
			end else if (address == `OLS_REG_IRQ_MASK) begin
				readdata <= {29'h0, irq_mask};
			end else if (address == `OLS_REG_DIRECT_VOLT) begin
				readdata <= {16'h0, volt_out};
			end else if (address == `OLS_REG_DIRECT_CURR) begin
				readdata <= {16'h0, curr_out};
			end else begin
				readdata <= 32'h0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------------
	// A new event beats a write-one-to-clear in the same cycle.
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_status <= 3'h0;
			irq_mask <= 3'h0;
			irq <= 1'b0;
		end else begin
			if (wr_en && address == `OLS_REG_IRQ_STATUS) begin
				irq_status <= (irq_status & ~writedata[2:0]) | events;
			end else begin
				irq_status <= irq_status | events;
			end
			if (wr_en && address == `OLS_REG_IRQ_MASK) begin
				irq_mask <= writedata[2:0];
			end
			irq <= |(irq_status & irq_mask);
		end
	end

	// ------------------------------------------------------------------------
	// Point lists
	// ------------------------------------------------------------------------
	// Full lists and out-of-range dwell entries are refused.
	assign reject = (append[`OLS_VOLTAGE_POINT_LIST] && len[`OLS_VOLTAGE_POINT_LIST] == AW'(MAX_POINTS)) ||
		(append[`OLS_CURRENT_POINT_LIST] && len[`OLS_CURRENT_POINT_LIST] == AW'(MAX_POINTS)) ||
		(append[`OLS_LIST_DWELL] && (len[`OLS_LIST_DWELL] == AW'(MAX_POINTS) ||
		writedata[15:0] < `OLS_DWELL_MIN || writedata[15:0] > `OLS_DWELL_MAX));

	for (genvar l = 0; l < 3; l++) begin : g_list
		// Appends land at the end, so playback order is loading order.
		always_ff @(posedge clock) begin
			if (rst || (wr_en && address == `OLS_REG_CLEAR && writedata[l])) begin
				len[l] <= '0;
			end else if (append[l] && !reject) begin
				len[l] <= len[l] + 1'b1;
			end
		end
		// A single-point list always reads its only entry.
		assign raddr[l] = (len[l] == AW'(1)) ? '0 : idx;
		ols_point_mem #(.DEPTH(MAX_POINTS), .AW(AW)) u_mem (
			.clock(clock),
			.we(append[l] && !reject),
			.waddr(len[l]),
			.wdata(writedata[15:0]),
			.raddr(raddr[l]),
			.rdata(rdata[l])
		);
		AST_SINGLE_ADDR: assert property (@(posedge clock) disable iff (rst)
			len[l] == AW'(1) |-> raddr[l] == '0) else $error("single point list not repeated");
		AST_LEN_MAX: assert property (@(posedge clock) disable iff (rst)
			len[l] <= AW'(MAX_POINTS)) else $error("list longer than allowed");
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	logic trig_ok, tick, point_end, last_pt, endless, finish, lens_ok;
	logic [AW-1:0] n_max;

	// Unarmed triggers never reach the sequencer.
	assign trig_ok = (trigger || trig_wr) && ctrl[`OLS_CTRL_ARMED];
	assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));
	assign point_end = state == S_DWELL && tick && dwell_left == 16'd1;
	assign last_pt = idx == n_pts - 1'b1;
	assign endless = repeat_count_setting > `OLS_ENDLESS_LIMIT;
	// Finished only after the programmed number of full passes.
	assign finish = point_end && last_pt && !endless && 32'(pass) + 32'd1 >= repeat_count_setting;

	// Lists must agree in length, one-point lists excepted.
	always_comb begin
		n_max = len[0];
		if (len[1] > n_max) begin
			n_max = len[1];
		end
		if (len[2] > n_max) begin
			n_max = len[2];
		end
		lens_ok = n_max != '0;
		for (int l = 0; l < 3; l++) begin
			if (len[l] != n_max && len[l] != AW'(1)) begin
				lens_ok = 1'b0;
			end
		end
	end

	always_comb begin
		events = 3'h0;
		events[`OLS_IRQ_MISMATCH] = state == S_IDLE && trig_ok && !seq_cmd && !lens_ok;
		events[`OLS_IRQ_DONE] = finish && !seq_cmd;
		events[`OLS_IRQ_REJECT] = reject;
	end

	// State, point index and pass counter.
	always_ff @(posedge clock) begin
		if (rst || seq_cmd) begin
			state <= S_IDLE;
			idx <= '0;
			pass <= 16'h0;
			n_pts <= '0;
		end else begin
			case (state)
				S_IDLE: begin
					if (trig_ok && lens_ok) begin
						state <= S_FETCH;
						idx <= '0;
						pass <= 16'h0;
						n_pts <= n_max;
					end
				end
				S_FETCH: state <= S_APPLY;
				S_APPLY: state <= S_DWELL;
				S_DWELL: begin
					// Triggers here fall through unused.
					if (point_end) begin
						if (finish) begin
							state <= S_IDLE;
						end else begin
							if (last_pt) begin
								idx <= '0;
								pass <= endless ? pass : pass + 16'd1;
							end else begin
								idx <= idx + 1'b1;
							end
							state <= ctrl[`OLS_CTRL_STEP_ONCE] ? S_HOLD : S_FETCH;
						end
					end
				end
				S_HOLD: begin
					if (trig_ok) begin
						state <= S_FETCH;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Dwell timer: a 10 ms tick divider and a tick countdown.
	always_ff @(posedge clock) begin
		if (rst || state != S_DWELL || tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dwell_left <= 16'h0;
		end else if (state == S_APPLY) begin
			dwell_left <= rdata[`OLS_LIST_DWELL];
		end else if (state == S_DWELL && tick) begin
			dwell_left <= dwell_left - 16'd1;
		end
	end

	// Output levels: direct writes always apply, lists only where selected.
	always_ff @(posedge clock) begin
		if (rst) begin
			volt_out <= 16'h0;
			curr_out <= 16'h0;
		end else begin
			if (direct_v) begin
				volt_out <= writedata[15:0];
			end else if (state == S_APPLY && ctrl[`OLS_CTRL_VOLT_LIST]) begin
				volt_out <= rdata[`OLS_VOLTAGE_POINT_LIST];
			end
			if (direct_c) begin
				curr_out <= writedata[15:0];
			end else if (state == S_APPLY && ctrl[`OLS_CTRL_CURR_LIST]) begin
				curr_out <= rdata[`OLS_CURRENT_POINT_LIST];
			end
		end
	end

	AST_MISMATCH: assert property (@(posedge clock) disable iff (rst)
		state == S_IDLE && trig_ok && !seq_cmd && !lens_ok |=> irq_status[`OLS_IRQ_MISMATCH] && state == S_IDLE)
		else $error("length mismatch not flagged");
	AST_ABORT: assert property (@(posedge clock) disable iff (rst)
		seq_cmd |=> state == S_IDLE) else $error("command did not abort sequence");
	AST_ENDLESS: assert property (@(posedge clock) disable iff (rst)
		endless |-> !finish) else $error("endless run finished");
	AST_ORDER: assert property (@(posedge clock) disable iff (rst)
		point_end && !last_pt && !seq_cmd |=> idx == $past(idx) + 1'b1) else $error("points out of order");
	AST_DWELL_HOLD: assert property (@(posedge clock) disable iff (rst)
		state == S_DWELL && !direct_v ##1 state == S_DWELL |-> $stable(volt_out))
		else $error("voltage moved during dwell");
	AST_AUTO: assert property (@(posedge clock) disable iff (rst)
		point_end && !finish && !seq_cmd && !ctrl[`OLS_CTRL_STEP_ONCE] |=> state == S_FETCH ##2 state == S_DWELL)
		else $error("auto mode did not advance");
	AST_ONCE: assert property (@(posedge clock) disable iff (rst)
		point_end && !finish && !seq_cmd && ctrl[`OLS_CTRL_STEP_ONCE] |=> state == S_HOLD)
		else $error("step mode did not hold");
	AST_IGNORE: assert property (@(posedge clock) disable iff (rst)
		state == S_DWELL && trig_ok && !point_end && !seq_cmd |=> state == S_DWELL && $stable(idx))
		else $error("trigger acted during dwell");
	AST_FIXED_CURR: assert property (@(posedge clock) disable iff (rst)
		!ctrl[`OLS_CTRL_CURR_LIST] && !direct_c |=> $stable(curr_out))
		else $error("fixed current changed by list");
	AST_UNARMED: assert property (@(posedge clock) disable iff (rst)
		state == S_IDLE && !ctrl[`OLS_CTRL_ARMED] |=> state == S_IDLE)
		else $error("unarmed trigger started list");
endmodule // ols_list_sequencer

// ---- tb/ols_host.sv ----
// ----------------------------------------------------------------------------
// Remote controller model: a plain Avalon-MM master driven by task calls.
// ----------------------------------------------------------------------------
module ols_host (
	input wire logic clock, // System clock.
	output logic [5:0] address, // Byte address.
	output logic read, // Read request.
	output logic write, // Write request.
	output logic [31:0] writedata, // Write data.
	input wire logic [31:0] readdata, // Read data.
	input wire logic waitrequest, // Slave stall.
	output logic rd_done, // One-cycle pulse once read data were taken.
	output logic [31:0] rd_data // Read data taken at the completing edge.
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus from time zero.
	initial begin
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		rd_done = 1'b0;
		rd_data = 32'h0;
	end

	// The request stays put until waitrequest is seen low, so a slow slave only stretches it.
	// Values read right after the edge are the ones the edge sampled, as the slave updates by NBA.
	task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		read <= ~w;
		write <= w;
		writedata <= d;
		@(posedge clock);
		while (waitrequest !== 1'b0) @(posedge clock);
		rd_data <= readdata;
		rd_done <= ~w;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
		rd_done <= 1'b0;
	endtask
endmodule // ols_host

// ---- tb/tb.sv ----
`include "ols_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ols_pkg::*;
	logic clock, rst, read, write, waitrequest, trigger, irq, rd_done;
	logic [5:0] address;
	logic [31:0] writedata, readdata, rd_data, last_pt;
	ols_point_t volt_out, curr_out, mv, mc;
	ols_point_t vl[3];
	ols_point_t cl[3];
	logic [31:0] exp_rd[$];
	logic [31:0] exp_pt[$];
	int miscompares, n_checks;

	// ----------------------------------------------------------------------------
	// Design, controller model and clock
	// ----------------------------------------------------------------------------
	ols_list_sequencer #(.TICK_CYCLES(4)) ols_list_sequencer_inst (.clock(clock), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.trigger(trigger), .volt_out(volt_out), .curr_out(curr_out), .irq(irq));
	ols_host ols_host_inst (.clock(clock), .address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .rd_done(rd_done), .rd_data(rd_data));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ----------------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------------
	task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		ols_host_inst.xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		ols_host_inst.xfer(a, 1'b0, 32'h0);
	endtask
	task automatic pulse;
		@(posedge clock);
		trigger <= 1'b1;
		@(posedge clock);
		trigger <= 1'b0;
	endtask
	// Bounded wait: a run that never ends shows up as a low irq here.
	task automatic wait_irq;
		for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clock);
		compare("irq", 32'h1, {31'h0, irq});
	endtask
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Output watcher: every read answer and every change of the set-point pair takes the oldest note.
	always @(posedge clock) begin
		if (rst) begin
			last_pt <= 32'h0;
		end else begin
			if (rd_done) compare("readdata", exp_rd.pop_front(), rd_data);
			if ({volt_out, curr_out} !== last_pt) begin
				last_pt <= {volt_out, curr_out};
				if (exp_pt.size() == 0) compare("unexpected point", last_pt, {volt_out, curr_out});
				else compare("point", exp_pt.pop_front(), {volt_out, curr_out});
			end
		end
	end

	// A hang ends the run through the normal verdict.
	initial begin
		#(20000 * 50);
		miscompares++;
		give_verdict;
	end

	// ----------------------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		trigger = 1'b0;
		miscompares = 0;
		n_checks = 0;
		void'($urandom(32'h7e2e));
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		compare("waitrequest idle", 32'h1, {31'h0, waitrequest});
		rd(`OLS_REG_CTRL, 32'h0);
		rd(`OLS_REG_REPEAT, 32'h1);
		rd(`OLS_REG_LENGTHS, 32'h0);
		rd(6'h3c, 32'h0);
		wr(`OLS_REG_REPEAT, 32'h0);
		rd(`OLS_REG_REPEAT, 32'h1);
		$display("Done: reset values");
		// Direct levels reach the outputs while both sources are fixed.
		mv = 16'($urandom) | 16'h1;
		mc = 16'($urandom) | 16'h1;
		exp_pt.push_back({mv, 16'h0});
		wr(`OLS_REG_DIRECT_VOLT, {16'h0, mv});
		exp_pt.push_back({mv, mc});
		wr(`OLS_REG_DIRECT_CURR, {16'h0, mc});
		rd(`OLS_REG_DIRECT_VOLT, {16'h0, mv});
		rd(`OLS_REG_DIRECT_CURR, {16'h0, mc});
		$display("Done: direct levels");
		// Automatic run, two passes; a trigger inside the first dwell must change nothing.
		for (int i = 0; i < 3; i++) begin
			vl[i] = 16'($urandom);
			cl[i] = 16'($urandom);
			wr(`OLS_REG_VOLT_APPEND, {16'h0, vl[i]});
			wr(`OLS_REG_CURR_APPEND, {16'h0, cl[i]});
			wr(`OLS_REG_DWELL_APPEND, 32'(3 - i));
		end
		rd(`OLS_REG_LENGTHS, 32'h0003_0303);
		wr(`OLS_REG_REPEAT, 32'h2);
		wr(`OLS_REG_IRQ_MASK, 32'h2);
		wr(`OLS_REG_CTRL, 32'he);
		for (int p = 0; p < 6; p++) exp_pt.push_back({vl[p % 3], cl[p % 3]});
		pulse;
		repeat (3) @(posedge clock);
		pulse;
		wait_irq;
		compare("points left", 32'h0, 32'(exp_pt.size()));
		compare("held point", {vl[2], cl[2]}, {volt_out, curr_out});
		rd(`OLS_REG_IRQ_STATUS, 32'h2);
		wr(`OLS_REG_IRQ_STATUS, 32'h2);
		repeat (2) @(posedge clock);
		compare("irq cleared", 32'h0, {31'h0, irq});
		$display("Done: automatic run");
		// Four voltage points against three: refused at the trigger, first masked, then unmasked.
		wr(`OLS_REG_VOLT_APPEND, 32'h1);
		pulse;
		repeat (4) @(posedge clock);
		compare("masked irq", 32'h0, {31'h0, irq});
		rd(`OLS_REG_IRQ_STATUS, 32'h1);
		wr(`OLS_REG_IRQ_MASK, 32'h7);
		wait_irq;
		wr(`OLS_REG_IRQ_STATUS, 32'h1);
		wr(`OLS_REG_CTRL, 32'h6);
		pulse;
		repeat (4) @(posedge clock);
		rd(`OLS_REG_IRQ_STATUS, 32'h0);
		$display("Done: mismatch and unarmed");
		// Single step, fixed current, one-point current and dwell lists, abort in the hold, then endless.
		// The current output still carries the last list value of the automatic run.
		wr(`OLS_REG_CLEAR, 32'h7);
		wr(`OLS_REG_VOLT_APPEND, {16'h0, vl[0]});
		wr(`OLS_REG_VOLT_APPEND, {16'h0, vl[1]});
		wr(`OLS_REG_CURR_APPEND, {16'h0, ~cl[2]});
		wr(`OLS_REG_DWELL_APPEND, 32'h1);
		wr(`OLS_REG_REPEAT, 32'h1);
		wr(`OLS_REG_CTRL, 32'hd);
		exp_pt.push_back({vl[0], cl[2]});
		pulse;
		repeat (30) @(posedge clock);
		rd(`OLS_REG_STATUS, 32'h0000_0103);
		wr(`OLS_REG_CTRL, 32'hd);
		pulse;
		repeat (30) @(posedge clock);
		exp_pt.push_back({vl[1], cl[2]});
		wr(`OLS_REG_TRIGGER, 32'h1);
		repeat (30) @(posedge clock);
		compare("points left", 32'h0, 32'(exp_pt.size()));
		rd(`OLS_REG_STATUS, 32'h0000_0100);
		// Endless count: the last point wraps to the first and the pass counter stays put.
		wr(`OLS_REG_REPEAT, 32'h0001_0000);
		exp_pt.push_back({vl[0], cl[2]});
		pulse;
		repeat (30) @(posedge clock);
		exp_pt.push_back({vl[1], cl[2]});
		pulse;
		repeat (30) @(posedge clock);
		rd(`OLS_REG_STATUS, 32'h0000_0003);
		$display("Done: single step");
		// Full list and dwell limits: refused appends leave the lengths alone.
		wr(`OLS_REG_CLEAR, 32'h7);
		for (int i = 0; i < 21; i++) wr(`OLS_REG_VOLT_APPEND, $urandom & 32'hffff);
		wr(`OLS_REG_DWELL_APPEND, 32'h0);
		wr(`OLS_REG_DWELL_APPEND, 32'd6501);
		rd(`OLS_REG_LENGTHS, 32'h0000_0014);
		wr(`OLS_REG_DWELL_APPEND, 32'd6500);
		rd(`OLS_REG_LENGTHS, 32'h0001_0014);
		rd(`OLS_REG_IRQ_STATUS, 32'h6);
		$display("Done: list limits");
		give_verdict;
	end
endmodule // tb
